//--- logic/lbsc_core.sv
// Added by the designer: the placing of the registers and register access over Wishbone.
`default_nettype none
`include "lbsc_defines.svh"
module lbsc_core (
  input  wire logic                  clk_i,          // 10 MHz clock
  input  wire logic                  rst_i,          // Power-on reset
  input  wire logic                  pgood_i,        // Supply good
  input  wire logic                  en_i,           // Enable pin
  input  wire lbsc_pkg::lbsc_wb_req_s wb_i,          // Wishbone request
  output      lbsc_pkg::lbsc_wb_rsp_s wb_o,          // Wishbone answer
  input  wire lbsc_pkg::lbsc_ch_t    pwm_open_i,     // PWM asks switch open
  input  wire lbsc_pkg::lbsc_ch_t    duty_zero_i,    // Duty is zero
  input  wire lbsc_pkg::lbsc_ch_t    duty_full_i,    // Duty is 100%
  input  wire lbsc_pkg::lbsc_ch_t    cmp_open_i,     // Overvoltage comparator
  input  wire lbsc_pkg::lbsc_ch_t    cmp_short_i,    // Below-short comparator
  input  wire lbsc_pkg::lbsc_ch_t    cmp_trace_i,    // Low-current comparator
  input  wire logic                  thermal_warning_flag_i,      // Die above warning
  input  wire logic                  thermal_shutdown_flag_i,      // Die above shutdown
  output      lbsc_pkg::lbsc_ch_t    sw_closed_o,    // Bypass switch closed
  output      logic                  ovth_sel_o,     // Open threshold 9.0V
  output      logic                  sth_sel_o,      // Short threshold 4.4V
  output      logic                  fault_alert_n_o, // Fault pin level
  output      logic                  fault_alert_oe_o // Fault pin driven low
);
  import lbsc_pkg::*;

  lbsc_state_s s;
  lbsc_state_s next_s;

  // ----------------------------------------
  // Helper terms
  // ----------------------------------------
  logic     run;
  logic     live;
  logic     wr_ok;
  logic     bus_go;
  lbsc_ch_t open_req;
  lbsc_ch_t req_rise;
  logic [4:0] gen;

  // Supply and enable gate the core, but not bus reads or the shutdown drive of the fault pin
  assign live   = pgood_i & en_i;
  // LED faults count only while switching runs
  assign run    = live & s.go_en;
  assign bus_go = wb_i.cyc & wb_i.stb & ~s.ack;
  assign wr_ok  = bus_go & wb_i.we & wb_i.sel[0] & live;
  // PWM request only honoured for dimming-enabled channels
  assign open_req = pwm_open_i & s.dim_en & {`LBSC_NCH{run}};
  assign req_rise = open_req & ~s.req_q;

  // General status summary
  assign gen = {|s.stat_trace, |s.stat_short, |s.stat_open, s.shdn, s.warn};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    // Comparator synchronisers, first stage read only by second
    next_s.so1 = cmp_open_i;
    next_s.so2 = s.so1;
    next_s.ss1 = cmp_short_i;
    next_s.ss2 = s.ss1;
    next_s.st1 = cmp_trace_i;
    next_s.st2 = s.st1;
    next_s.req_q = open_req;
    // Bus answer one cycle after request
    next_s.ack  = bus_go;
    next_s.rdat = 32'h0000_0000;
    if (bus_go && !wb_i.we) begin
      case (wb_i.adr)
        `LBSC_OFF_CTRL: next_s.rdat = {28'h0, s.shdn_open, s.sth_hi, s.ovth_hi, s.go_en};
        `LBSC_OFF_DIM:  next_s.rdat = {20'h0, s.dim_en};
        `LBSC_OFF_GEN:  next_s.rdat = {27'h0, gen};
        `LBSC_OFF_OPEN: next_s.rdat = {20'h0, s.stat_open};
        `LBSC_OFF_SHRT: next_s.rdat = {20'h0, s.stat_short};
        `LBSC_OFF_TRCE: next_s.rdat = {20'h0, s.stat_trace};
        default:        next_s.rdat = 32'h0000_0000;
      endcase
      // Reads clear status; fresh events below set again
      case (wb_i.adr)
        `LBSC_OFF_GEN: begin
          next_s.warn = 1'b0;
          next_s.shdn = 1'b0;
        end
        `LBSC_OFF_OPEN: next_s.stat_open  = '0;
        `LBSC_OFF_SHRT: next_s.stat_short = '0;
        `LBSC_OFF_TRCE: next_s.stat_trace = '0;
        default: begin
        end
      endcase
    end
    // Register writes from the host
    if (wr_ok) begin
      case (wb_i.adr)
        `LBSC_OFF_CTRL: begin
          next_s.go_en     = wb_i.dat[`LBSC_CTRL_GO];
          next_s.ovth_hi   = wb_i.dat[`LBSC_CTRL_OVTH];
          next_s.sth_hi    = wb_i.dat[`LBSC_CTRL_STH];
          next_s.shdn_open = wb_i.dat[`LBSC_CTRL_SHOP];
        end
        `LBSC_OFF_DIM: begin
          if (wb_i.sel[1]) begin
            next_s.dim_en = wb_i.dat[`LBSC_NCH-1:0];
          end else begin
            next_s.dim_en[7:0] = wb_i.dat[7:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Thermal events; set wins over read clear
    if (thermal_warning_flag_i) begin
      next_s.warn = 1'b1;
    end
    if (thermal_shutdown_flag_i) begin
      next_s.shdn = 1'b1;
    end
    // Per-channel switch and diagnostics, fully independent
    for (int c = 0; c < `LBSC_NCH; c++) begin
      // New open request releases the open-LED latch
      if (req_rise[c]) begin
        next_s.olatch[c] = 1'b0;
      end
      // Open LED seen on an open switch: close and flag
      if (run && s.sw_open[c] && !duty_zero_i[c] && s.so2[c]) begin
        next_s.olatch[c]    = 1'b1;
        next_s.stat_open[c] = 1'b1;
      end
      // Switch follows PWM unless latched by protection
      next_s.sw_open[c] = open_req[c] & ~next_s.olatch[c];
      if (thermal_shutdown_flag_i) begin
        next_s.sw_open[c] = s.shdn_open & live;
      end
      // Short sampled as the LED-on pulse ends
      if (run && s.sw_open[c] && !next_s.sw_open[c]
          && !duty_zero_i[c] && s.ss2[c]) begin
        next_s.stat_short[c] = 1'b1;
      end
      // Low current sampled just before the closed switch opens
      if (run && req_rise[c] && !s.sw_open[c]
          && !duty_full_i[c] && s.st2[c]) begin
        next_s.stat_trace[c] = 1'b1;
      end
    end
    // Supply loss or enable low: back to defaults
    if (!live) begin
      next_s.go_en      = 1'b0;
      next_s.ovth_hi    = 1'b0;
      next_s.sth_hi     = 1'b0;
      next_s.shdn_open  = 1'b0;
      next_s.dim_en     = `LBSC_RST_CH;
      next_s.stat_open  = `LBSC_RST_CH;
      next_s.stat_short = `LBSC_RST_CH;
      next_s.stat_trace = `LBSC_RST_CH;
      next_s.warn       = 1'b0;
      next_s.shdn       = 1'b0;
      next_s.olatch     = `LBSC_RST_CH;
      next_s.sw_open    = `LBSC_RST_CH;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Wishbone answer
  assign wb_o.ack = s.ack;
  assign wb_o.dat = s.rdat;
  // Switch drive and threshold selects
  assign sw_closed_o = ~s.sw_open;
  assign ovth_sel_o  = s.ovth_hi;
  assign sth_sel_o   = s.sth_hi;
  // Open-drain fault pin, low while any general bit stands
  assign fault_alert_n_o  = 1'b0;
  assign fault_alert_oe_o = (gen != 5'h00) | thermal_shutdown_flag_i;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_por_closed;
    $fell(rst_i) |-> (sw_closed_o == 12'hFFF) && (s.dim_en == 12'h000);
  endproperty
  a_por_closed: assert property (p_por_closed)
    else $error("switches not closed after reset");

  property p_en_low;
    !en_i |=> (sw_closed_o == 12'hFFF) && !s.go_en && (gen == 5'h00);
  endproperty
  a_en_low: assert property (p_en_low)
    else $error("enable low did not restore defaults");

  property p_pgood_low;
    !pgood_i |=> (s.dim_en == 12'h000) && !s.ovth_hi && !s.sth_hi;
  endproperty
  a_pgood_low: assert property (p_pgood_low)
    else $error("supply loss did not restore defaults");

  property p_wr_gate;
    (bus_go && wb_i.we && !en_i) |=> !s.go_en ##1 $stable(s.go_en);
  endproperty
  a_wr_gate: assert property (p_wr_gate)
    else $error("write taken while disabled");

  property p_no_dim;
    (s.dim_en == 12'h000) && !thermal_shutdown_flag_i |=> sw_closed_o == 12'hFFF;
  endproperty
  a_no_dim: assert property (p_no_dim)
    else $error("switch opened without dimming enabled");

  // Shutdown pulls the pin at once and is latched while the core is live
  property p_shdn_fault;
    thermal_shutdown_flag_i && live |-> fault_alert_oe_o ##1 s.shdn;
  endproperty
  a_shdn_fault: assert property (p_shdn_fault)
    else $error("shutdown not signalled");

  property p_olatch;
    $rose(s.olatch[0]) |-> sw_closed_o[0] && $past(s.so2[0]);
  endproperty
  a_olatch: assert property (p_olatch)
    else $error("open LED did not close switch");

  // Any newly flagged short must sit on a switch that just closed
  property p_short_end;
    |(s.stat_short & ~$past(s.stat_short)) |->
      (s.stat_short & ~$past(s.stat_short) & ~($past(s.sw_open) & ~s.sw_open)) == 12'h000;
  endproperty
  a_short_end: assert property (p_short_end)
    else $error("short sampled outside pulse end");

  // Pin released only by a status read or by a return to defaults
  property p_fault_release;
    $fell(fault_alert_oe_o) |-> wb_o.ack || !$past(live);
  endproperty
  a_fault_release: assert property (p_fault_release)
    else $error("fault released with status set");

  property p_no_run;
    !run |=> $stable(s.stat_open) || (s.stat_open == 12'h000);
  endproperty
  a_no_run: assert property (p_no_run)
    else $error("fault latched while not running");

  // Open flags only on a running, open switch with nonzero duty
  property p_open_gate;
    |(s.stat_open & ~$past(s.stat_open)) |->
      (s.stat_open & ~$past(s.stat_open) & ($past(duty_zero_i) | ~$past(s.sw_open)
       | {`LBSC_NCH{!$past(run)}})) == 12'h000;
  endproperty
  a_open_gate: assert property (p_open_gate)
    else $error("open fault flagged outside its window");

  // Low-current flags only on a closed switch whose duty is below full
  property p_trace_gate;
    |(s.stat_trace & ~$past(s.stat_trace)) |->
      (s.stat_trace & ~$past(s.stat_trace) & ($past(duty_full_i) | $past(s.sw_open)))
      == 12'h000;
  endproperty
  a_trace_gate: assert property (p_trace_gate)
    else $error("trace fault flagged outside its window");

  // Open comparator reaches the qualifier exactly two edges late
  property p_sync_open;
    s.so2 == $past(cmp_open_i, 2);
  endproperty
  a_sync_open: assert property (p_sync_open)
    else $error("open comparator not passed through two stages");

  // Threshold selects follow an accepted control write
  property p_thresh;
    wr_ok && (wb_i.adr == `LBSC_OFF_CTRL) |=> {sth_sel_o, ovth_sel_o} ==
      {$past(wb_i.dat[`LBSC_CTRL_STH]), $past(wb_i.dat[`LBSC_CTRL_OVTH])};
  endproperty
  a_thresh: assert property (p_thresh)
    else $error("threshold select not taken from write");

  // Warning condition is latched for software
  property p_warn_set;
    thermal_warning_flag_i && live |=> s.warn;
  endproperty
  a_warn_set: assert property (p_warn_set)
    else $error("thermal warning not latched");

  // Outside thermal shutdown, a protected switch stays closed until a fresh open request
  property p_olatch_hold;
    s.olatch[0] && live && !req_rise[0] && !thermal_shutdown_flag_i |=> s.olatch[0] && sw_closed_o[0];
  endproperty
  a_olatch_hold: assert property (p_olatch_hold)
    else $error("protected switch reopened early");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  // Main scenarios
  c_open_fault:  cover property ($rose(s.stat_open[0]));
  c_short_fault: cover property ($rose(s.stat_short[1]));
  c_switch_on:   cover property ($rose(s.sw_open[0]));
  c_thermal:     cover property ($rose(s.shdn));
  c_trace:       cover property ($rose(s.stat_trace[2]));

endmodule // lbsc_core
`default_nettype wire

//--- logic/lbsc_defines.svh
`ifndef LBSC_DEFINES_SVH
`define LBSC_DEFINES_SVH
// Channel count
`define LBSC_NCH       12
// Register byte offsets
`define LBSC_OFF_CTRL  8'h00
`define LBSC_OFF_DIM   8'h04
`define LBSC_OFF_GEN   8'h08
`define LBSC_OFF_OPEN  8'h0C
`define LBSC_OFF_SHRT  8'h10
`define LBSC_OFF_TRCE  8'h14
// Control register fields
`define LBSC_CTRL_GO   0
`define LBSC_CTRL_OVTH 1
`define LBSC_CTRL_STH  2
`define LBSC_CTRL_SHOP 3
// General status fields
`define LBSC_GEN_WARN  0
`define LBSC_GEN_SHDN  1
`define LBSC_GEN_OPEN  2
`define LBSC_GEN_SHRT  3
`define LBSC_GEN_TRCE  4
// Reset values
`define LBSC_RST_CTRL  4'h0
`define LBSC_RST_CH    12'h000
`endif

//--- logic/lbsc_pkg.sv
`default_nettype none
`include "lbsc_defines.svh"
package lbsc_pkg;
  typedef logic [`LBSC_NCH-1:0] lbsc_ch_t;
  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } lbsc_wb_req_s;
  // Wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } lbsc_wb_rsp_s;
  // Whole state of the control core
  typedef struct packed {
    logic     go_en;
    logic     ovth_hi;
    logic     sth_hi;
    logic     shdn_open;
    lbsc_ch_t dim_en;
    lbsc_ch_t stat_open;
    lbsc_ch_t stat_short;
    lbsc_ch_t stat_trace;
    logic     warn;
    logic     shdn;
    lbsc_ch_t olatch;
    lbsc_ch_t sw_open;
    lbsc_ch_t req_q;
    lbsc_ch_t so1;
    lbsc_ch_t so2;
    lbsc_ch_t ss1;
    lbsc_ch_t ss2;
    lbsc_ch_t st1;
    lbsc_ch_t st2;
    logic     ack;
    logic [31:0] rdat;
  } lbsc_state_s;
endpackage : lbsc_pkg
`default_nettype wire

//--- tb/lbsc_led_model.sv
`default_nettype none
// ----------------------------------------------------------------
// LED string and per-switch comparators facing the core
// ----------------------------------------------------------------
module lbsc_led_model (
  input  wire logic               open_led_i,  // LED of channel 0 broken
  input  wire logic               short_led_i, // LED of channel 1 shorted
  input  wire logic               trace_cut_i, // Trace of channel 2 broken
  input  wire lbsc_pkg::lbsc_ch_t sw_closed_i, // Bypass switch state
  output var  lbsc_pkg::lbsc_ch_t cmp_open_o,  // Overvoltage across switch
  output var  lbsc_pkg::lbsc_ch_t cmp_short_o, // Drop below short level
  output var  lbsc_pkg::lbsc_ch_t cmp_trace_o  // String current too low
);
  timeunit 1ns;
  timeprecision 1ns;
  import lbsc_pkg::*;
  // Only an open switch across a broken LED sees overvoltage
  assign cmp_open_o  = {11'h000, open_led_i} & ~sw_closed_i;
  // A closed switch always reads as a short, so sampling time matters
  assign cmp_short_o = sw_closed_i | {10'h000, short_led_i, 1'b0};
  // A cut trace starves the closed switch of channel 2 of current
  assign cmp_trace_o = {9'h000, trace_cut_i, 2'b00} & sw_closed_i;
endmodule // lbsc_led_model
`default_nettype wire

//--- tb/tb.sv
`default_nettype none
`include "lbsc_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lbsc_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         pgood = 1'b1;
  logic         en = 1'b0;
  lbsc_wb_req_s wb = '0;
  lbsc_wb_rsp_s rsp;
  lbsc_ch_t     pwm = '0;
  lbsc_ch_t     c_open, c_short, c_trace, sw;
  logic         warn = 1'b0;
  logic         shdn = 1'b0;
  logic         open_led = 1'b0;
  logic         short_led = 1'b0;
  logic         trace_cut = 1'b0;
  lbsc_ch_t     dzero = '0;
  lbsc_ch_t     dfull = '0;
  logic         ovth, sth, alert_n, oe;
  logic [31:0]  rd;
  int           n_fail = 0;
  int           checks_done = 0;
  int           cycles = 0;
  // ----------------------------------------------------------------
  // Block and far side
  // ----------------------------------------------------------------
  lbsc_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .pgood_i(pgood), .en_i(en),
    .wb_i(wb), .wb_o(rsp), .pwm_open_i(pwm), .duty_zero_i(dzero),
    .duty_full_i(dfull), .cmp_open_i(c_open), .cmp_short_i(c_short),
    .cmp_trace_i(c_trace), .thermal_warning_flag_i(warn), .thermal_shutdown_flag_i(shdn), .sw_closed_o(sw),
    .ovth_sel_o(ovth), .sth_sel_o(sth), .fault_alert_n_o(alert_n),
    .fault_alert_oe_o(oe));
  lbsc_led_model led_u (.open_led_i(open_led), .short_led_i(short_led),
    .trace_cut_i(trace_cut),
    .sw_closed_i(sw), .cmp_open_o(c_open), .cmp_short_o(c_short),
    .cmp_trace_o(c_trace));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic single cycle, held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    rd = rsp.dat;
    wb <= '0;
    chk(32'(rsp.ack), 32'h1);
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(32'(sw), 32'hFFF);
    chk(32'({ovth, sth, oe}), 32'h0);
    rd_chk(`LBSC_OFF_CTRL, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_enable;
    pwm <= 12'hFFF;
    wb_xfer(1'b1, `LBSC_OFF_CTRL, 32'h7);
    wb_xfer(1'b1, `LBSC_OFF_DIM, 32'hFFF);
    tick(3);
    chk(32'(sw), 32'hFFF);
    chk(32'({ovth, sth}), 32'h0);
    en <= 1'b1;
    tick(3);
    chk(32'(sw), 32'hFFF);
    rd_chk(`LBSC_OFF_DIM, 32'h0);
    wb_xfer(1'b1, `LBSC_OFF_CTRL, 32'h7);
    wb_xfer(1'b1, `LBSC_OFF_DIM, 32'hFFF);
    tick(3);
    chk(32'({ovth, sth}), 32'h3);
    chk(32'(sw), 32'h0);
    pgood <= 1'b0;
    tick(3);
    chk(32'(sw), 32'hFFF);
    rd_chk(`LBSC_OFF_CTRL, 32'h0);
    pgood <= 1'b1;
    $display("test enable done");
  endtask
  task automatic t_open;
    wb_xfer(1'b1, `LBSC_OFF_CTRL, 32'h1);
    wb_xfer(1'b1, `LBSC_OFF_DIM, 32'hFFF);
    tick(3);
    open_led <= 1'b1;
    tick(6);
    chk(32'(sw), 32'h001);
    chk(32'(oe), 32'h1);
    open_led <= 1'b0;
    tick(4);
    chk(32'(sw), 32'h001);
    pwm <= 12'h000;
    tick(2);
    pwm <= 12'hFFF;
    tick(3);
    chk(32'(sw), 32'h000);
    rd_chk(`LBSC_OFF_GEN, 32'h4);
    rd_chk(`LBSC_OFF_OPEN, 32'h1);
    tick(1);
    chk(32'(oe), 32'h0);
    $display("test open done");
  endtask
  task automatic t_short;
    short_led <= 1'b1;
    tick(4);
    chk(32'(sw), 32'h000);
    pwm <= 12'hFFD;
    tick(3);
    chk(32'(sw), 32'h002);
    short_led <= 1'b0;
    rd_chk(`LBSC_OFF_SHRT, 32'h2);
    $display("test short done");
  endtask
  task automatic t_therm;
    warn <= 1'b1;
    shdn <= 1'b1;
    tick(3);
    chk(32'(oe), 32'h1);
    chk(32'(alert_n), 32'h0);
    chk(32'(sw), 32'hFFF);
    rd_chk(`LBSC_OFF_GEN, 32'h3);
    warn <= 1'b0;
    shdn <= 1'b0;
    tick(2);
    rd_chk(`LBSC_OFF_GEN, 32'h3);
    tick(1);
    chk(32'(oe), 32'h0);
    $display("test thermal done");
  endtask
  task automatic t_duty;
    dzero <= 12'h001;
    open_led <= 1'b1;
    tick(5);
    chk(32'(sw), 32'h002);
    open_led <= 1'b0;
    tick(3);
    dzero <= 12'h000;
    rd_chk(`LBSC_OFF_OPEN, 32'h0);
    trace_cut <= 1'b1;
    dfull <= 12'h004;
    pwm <= 12'hFF9;
    tick(4);
    pwm <= 12'hFFD;
    tick(3);
    rd_chk(`LBSC_OFF_TRCE, 32'h0);
    dfull <= 12'h000;
    pwm <= 12'hFF9;
    tick(4);
    pwm <= 12'hFFD;
    tick(3);
    rd_chk(`LBSC_OFF_GEN, 32'h10);
    rd_chk(`LBSC_OFF_TRCE, 32'h4);
    trace_cut <= 1'b0;
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(2);
    chk(32'(sw), 32'hFFF);
    rd_chk(`LBSC_OFF_DIM, 32'h0);
    $display("test duty done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      final_report;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(2);
    t_reset;
    t_enable;
    t_open;
    t_short;
    t_therm;
    t_duty;
    final_report;
  end
endmodule // tb
`default_nettype wire
